/* File: ascr_partner.sv */
// far-side model: external convert trigger source and converter result source
`timescale 1ns/1ps
module ascr_partner (
    input wire logic clk_i,            // system clock
    input wire logic fire_i,           // request one convert pulse
    input wire logic [3:0] channel_i,  // channel being converted
    output logic convert_o,            // convert trigger level
    output logic [11:0] result_o       // result for that channel
);
    int hold_cnt = 0;
    initial convert_o = 1'b0;
    // held a few cycles: the trigger is a level sampled on the system clock
    always @(posedge clk_i) begin
        if (fire_i) begin
            convert_o <= 1'b1;
            hold_cnt <= 3;
        end else if (hold_cnt > 1) begin
            hold_cnt <= hold_cnt - 1;
        end else begin
            convert_o <= 1'b0;
            hold_cnt <= 0;
        end
    end
    // channel number in the result shows which conversion was kept
    assign result_o = {8'hA0, channel_i};
endmodule

/* File: ascr_pkg.sv */
// constants, field layout and types for the converter status and configuration register
package ascr_pkg;
    localparam int ADDR_W = 2;
    localparam int DATA_W = 16;
    localparam int CH_W = 4;
    localparam int RESULT_W = 12;
    localparam logic [1:0] OFS_STATUS = 2'h0;
    localparam logic [1:0] OFS_CTRL = 2'h1;
    localparam logic [1:0] OFS_DATA = 2'h2;
    localparam int RST_FLAG_BIT = 14;
    localparam int DONE_BIT = 13;
    localparam int ZERO_BIT = 12;
    localparam int REF_SEL_BIT = 7;
    localparam int REF_GAIN_BIT = 6;
    localparam int EXT_EN_BIT = 5;
    localparam int MODE_BIT = 15;
    localparam int FIRST_LSB = 8;
    localparam int LAST_LSB = 4;
    localparam logic RST_FLAG_RST = 1'h1;
    localparam logic DONE_RST = 1'h0;
    localparam logic REF_SEL_RST = 1'h0;
    localparam logic REF_GAIN_RST = 1'h0;
    localparam logic EXT_EN_RST = 1'h0;
    localparam logic MODE_RST = 1'h0;
    localparam logic [CH_W-1:0] CH_RST = 4'h0;
    localparam int CLK_MHZ = 250;
    localparam int DAV_PULSE_NS = 2000;
    localparam int DAV_PULSE_CYC = (DAV_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int CONV_NS = 5000;
    localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
    localparam int TMR_W = 11;
    typedef enum logic [0:0] {SEQ_IDLE, SEQ_CONV} ascr_seq_t;
endpackage

/* File: ascr_rise_det.sv */
// rising edge detector for a synchronous level
`timescale 1ns/1ps
module ascr_rise_det (
    input wire logic clk_i,      // system clock
    input wire logic rst_n_i,    // synchronous reset, active low
    input wire logic ce_i,       // clock enable
    input wire logic level_i,    // sampled level
    output logic rise_o          // one-cycle rise
);
    logic prev_q;
    logic prev_d;

    always_comb begin
        prev_d = level_i;
    end

    // reset to 1 so a level already high at reset is not taken as an edge
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prev_q <= 1'h1;
        end else if (ce_i) begin
            prev_q <= prev_d;
        end
    end

    assign rise_o = level_i & ~prev_q;
endmodule

/* File: ascr_timer.sv */
// reloadable down counter giving a busy level and an expiry pulse
`timescale 1ns/1ps
module ascr_timer #(
    parameter int W = 11,
    parameter int COUNT = 500
) (
    input wire logic clk_i,          // system clock
    input wire logic rst_n_i,        // synchronous reset, active low
    input wire logic ce_i,           // clock enable
    input wire logic start_i,        // load COUNT
    output logic busy_o,             // counter non-zero
    output logic expire_o,           // last busy cycle
    output logic [W-1:0] count_o     // remaining cycles
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (start_i) begin
            cnt_d = W'(COUNT);
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
        end else if (ce_i) begin
            cnt_q <= cnt_d;
        end
    end

    assign busy_o = (cnt_q != '0);
    assign expire_o = (cnt_q == W'(1));
    assign count_o = cnt_q;
endmodule

/* File: ascr_top.sv */
// converter status/configuration register with trigger select and channel sequencer
`timescale 1ns/1ps
module ascr_top #(
    parameter int CONV_CYCLES = ascr_pkg::CONV_CYC,
    parameter int DAV_CYCLES = ascr_pkg::DAV_PULSE_CYC
) (
    input wire logic CLK_I,                                   // 250 MHz clock
    input wire logic RST_N_I,                                 // sync reset, active low
    input wire logic CE_I,                                    // clock enable
    input wire logic [ascr_pkg::ADDR_W-1:0] ADDR_I,           // register address
    input wire logic [ascr_pkg::DATA_W-1:0] WDATA_I,          // write data
    input wire logic WR_I,                                    // write strobe
    input wire logic RD_I,                                    // read strobe
    output logic [ascr_pkg::DATA_W-1:0] RDATA_O,              // read data, next cycle
    input wire logic CONVERT_I,                               // external convert trigger
    input wire logic [ascr_pkg::RESULT_W-1:0] ADC_RESULT_I,   // converter result
    output logic [ascr_pkg::CH_W-1:0] ADC_CHANNEL_O,          // channel being converted
    output logic ADC_BUSY_O,                                  // sequence running
    output logic DATA_AVAILABLE_PIN_N_O,                      // data-available pin, low active
    output logic REF_INT_CONNECT_O,                           // internal ref to reference pin
    output logic REF_LEVEL_HIGH_O,                            // internal ref at 2.5 V
    output logic CS_REFERENCE_SELECT_O,                       // to current source
    output logic CS_REFERENCE_GAIN_O                          // to current source
);
    import ascr_pkg::*;

    logic rst_flag_q, rst_flag_d;
    logic done_q, done_d;
    logic ref_sel_q, ref_sel_d;
    logic ref_gain_q, ref_gain_d;
    logic ext_en_q, ext_en_d;
    logic mode_q, mode_d;
    logic [CH_W-1:0] first_q, first_d;
    logic [CH_W-1:0] last_q, last_d;
    logic [CH_W-1:0] ch_q, ch_d;
    logic [RESULT_W-1:0] result_q, result_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    ascr_seq_t seq_q, seq_d;

    logic wr_stat, wr_ctrl, rd_stat, rd_ctrl, rd_data;
    logic auto_eff, auto_eff_d;
    logic start_int, start_ext, start, conv_start, pass_end, abort;
    logic conv_expire, conv_busy;
    logic dav_start, dav_busy;
    logic [TMR_W-1:0] dav_count;
    logic conv_rise;
    logic [DATA_W-1:0] stat_word, ctrl_word;

    ascr_rise_det u_rise (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .level_i(CONVERT_I),
        .rise_o(conv_rise)
    );

    ascr_timer #(.W(TMR_W), .COUNT(CONV_CYCLES)) u_conv_tmr (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .start_i(conv_start),
        .busy_o(conv_busy),
        .expire_o(conv_expire),
        .count_o()
    );

    ascr_timer #(.W(TMR_W), .COUNT(DAV_CYCLES)) u_dav_tmr (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .start_i(dav_start),
        .busy_o(dav_busy),
        .expire_o(),
        .count_o(dav_count)
    );

    assign wr_stat = WR_I && (ADDR_I == OFS_STATUS);
    assign wr_ctrl = WR_I && (ADDR_I == OFS_CTRL);
    assign rd_stat = RD_I && (ADDR_I == OFS_STATUS);
    assign rd_ctrl = RD_I && (ADDR_I == OFS_CTRL);
    assign rd_data = RD_I && (ADDR_I == OFS_DATA);
    assign auto_eff = mode_q && !ext_en_q;

    // unused and bit 12 positions stay zero
    always_comb begin
        stat_word = '0;
        stat_word[RST_FLAG_BIT] = rst_flag_q;
        stat_word[DONE_BIT] = done_q;
        stat_word[REF_SEL_BIT] = ref_sel_q;
        stat_word[REF_GAIN_BIT] = ref_gain_q;
        stat_word[EXT_EN_BIT] = ext_en_q;
        ctrl_word = '0;
        ctrl_word[MODE_BIT] = mode_q;
        ctrl_word[FIRST_LSB +: CH_W] = first_q;
        ctrl_word[LAST_LSB +: CH_W] = last_q;
    end

    always_comb begin
        rst_flag_d = rst_flag_q;
        done_d = done_q;
        ref_sel_d = ref_sel_q;
        ref_gain_d = ref_gain_q;
        ext_en_d = ext_en_q;
        mode_d = mode_q;
        first_d = first_q;
        last_d = last_q;
        ch_d = ch_q;
        result_d = result_q;
        seq_d = seq_q;
        conv_start = 1'b0;
        pass_end = 1'b0;
        // configuration writes
        if (wr_stat) begin
            rst_flag_d = rst_flag_q & WDATA_I[RST_FLAG_BIT];
            ref_sel_d = WDATA_I[REF_SEL_BIT];
            ref_gain_d = WDATA_I[REF_GAIN_BIT];
            ext_en_d = WDATA_I[EXT_EN_BIT];
        end
        if (wr_ctrl) begin
            mode_d = WDATA_I[MODE_BIT];
            first_d = WDATA_I[FIRST_LSB +: CH_W];
            last_d = WDATA_I[LAST_LSB +: CH_W];
        end
        if (ext_en_d) begin
            mode_d = 1'b0;
        end
        auto_eff_d = mode_d && !ext_en_d;
        start_int = wr_ctrl && !ext_en_q;
        start_ext = ext_en_q && conv_rise && (seq_q == SEQ_IDLE);
        start = start_int || start_ext;
        abort = auto_eff && ext_en_d;
        // channel sequencer
        case (seq_q)
            SEQ_IDLE: begin
                seq_d = SEQ_IDLE;
            end
            SEQ_CONV: begin
                if (conv_expire) begin
                    result_d = ADC_RESULT_I;
                    if (ch_q == last_q) begin
                        pass_end = 1'b1;
                        if (auto_eff) begin
                            ch_d = first_q;
                            conv_start = 1'b1;
                        end else begin
                            seq_d = SEQ_IDLE;
                        end
                    end else begin
                        ch_d = ch_q + CH_W'(1);
                        conv_start = 1'b1;
                    end
                end
            end
            default: begin
                seq_d = SEQ_IDLE;
            end
        endcase
        if (start) begin
            seq_d = SEQ_CONV;
            ch_d = first_d;
            conv_start = 1'b1;
        end
        if (abort) begin
            seq_d = SEQ_IDLE;
            conv_start = 1'b0;
        end
        // host clears lose to a completing pass
        if ((wr_stat && !WDATA_I[DONE_BIT]) || rd_data) begin
            done_d = 1'b0;
        end
        if (pass_end && !auto_eff) begin
            done_d = 1'b1;
        end
        if (start || auto_eff_d) begin
            done_d = 1'b0;
        end
    end

    assign dav_start = pass_end && auto_eff;

    always_comb begin
        rdata_d = '0;
        if (rd_stat) begin
            rdata_d = stat_word;
        end else if (rd_ctrl) begin
            rdata_d = ctrl_word;
        end else if (rd_data) begin
            rdata_d = {{(DATA_W-RESULT_W){1'b0}}, result_q};
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            rst_flag_q <= RST_FLAG_RST;
            done_q <= DONE_RST;
            ref_sel_q <= REF_SEL_RST;
            ref_gain_q <= REF_GAIN_RST;
            ext_en_q <= EXT_EN_RST;
            mode_q <= MODE_RST;
            first_q <= CH_RST;
            last_q <= CH_RST;
            ch_q <= CH_RST;
            result_q <= '0;
            rdata_q <= '0;
            seq_q <= SEQ_IDLE;
        end else if (CE_I) begin
            rst_flag_q <= rst_flag_d;
            done_q <= done_d;
            ref_sel_q <= ref_sel_d;
            ref_gain_q <= ref_gain_d;
            ext_en_q <= ext_en_d;
            mode_q <= mode_d;
            first_q <= first_d;
            last_q <= last_d;
            ch_q <= ch_d;
            result_q <= result_d;
            rdata_q <= rdata_d;
            seq_q <= seq_d;
        end
    end

    assign RDATA_O = rdata_q;
    assign ADC_CHANNEL_O = ch_q;
    assign ADC_BUSY_O = (seq_q == SEQ_CONV);
    // pulse mode only while auto is in effect; otherwise the pin follows the flag
    assign DATA_AVAILABLE_PIN_N_O = auto_eff ? !dav_busy : !done_q;
    assign REF_INT_CONNECT_O = !ref_sel_q;
    assign REF_LEVEL_HIGH_O = ref_gain_q && !ref_sel_q;
    assign CS_REFERENCE_SELECT_O = ref_sel_q;
    assign CS_REFERENCE_GAIN_O = ref_gain_q;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    property p_rst_flag_no_set;
        $rose(rst_flag_q) |-> !$past(RST_N_I);
    endproperty
    a_rst_flag_no_set: assert property (p_rst_flag_no_set)
        else $error("reset flag set without reset");

    property p_done_on_pass;
        (CE_I && seq_q == SEQ_CONV && conv_expire && ch_q == last_q && !auto_eff && !start)
            |=> done_q && seq_q == SEQ_IDLE;
    endproperty
    a_done_on_pass: assert property (p_done_on_pass)
        else $error("done flag not set after direct pass");

    property p_auto_done_low;
        auto_eff |-> !done_q;
    endproperty
    a_auto_done_low: assert property (p_auto_done_low)
        else $error("done flag high in auto mode");

    property p_pin_direct;
        !auto_eff |-> DATA_AVAILABLE_PIN_N_O == !done_q;
    endproperty
    a_pin_direct: assert property (p_pin_direct)
        else $error("data-available pin not inverse of done flag");

    property p_auto_pulse;
        (CE_I && dav_start) |=> dav_count == TMR_W'(DAV_CYCLES) ##1 !DATA_AVAILABLE_PIN_N_O || !auto_eff;
    endproperty
    a_auto_pulse: assert property (p_auto_pulse)
        else $error("auto pulse not started at full length");

    property p_read_clears;
        (CE_I && rd_data && !pass_end) |=> !done_q;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("data read did not clear done flag");

    // only status reads: control and data words legally use bits 11:8
    property p_bit12_zero;
        (CE_I && rd_stat) |=> RDATA_O[15] == 1'h0 && RDATA_O[ZERO_BIT] == 1'h0
            && RDATA_O[11:8] == 4'h0 && RDATA_O[4:0] == 5'h00;
    endproperty
    a_bit12_zero: assert property (p_bit12_zero)
        else $error("reserved read bits not zero");

    property p_ext_start;
        (CE_I && ext_en_q && conv_rise && seq_q == SEQ_IDLE && !abort)
            |=> seq_q == SEQ_CONV && ch_q == first_q;
    endproperty
    a_ext_start: assert property (p_ext_start)
        else $error("external edge did not start sequence");

    property p_ctrl_no_start;
        (CE_I && wr_ctrl && ext_en_q && seq_q == SEQ_IDLE && !conv_rise) |=> seq_q == SEQ_IDLE;
    endproperty
    a_ctrl_no_start: assert property (p_ctrl_no_start)
        else $error("control write started conversion under external trigger");

    property p_ignore_convert;
        (CE_I && !ext_en_q && conv_rise && seq_q == SEQ_IDLE && !WR_I) |=> seq_q == SEQ_IDLE;
    endproperty
    a_ignore_convert: assert property (p_ignore_convert)
        else $error("convert input acted while disabled");

    property p_reset_clear;
        @(posedge CLK_I) disable iff (1'b0)
        !RST_N_I |=> !done_q && !ref_sel_q && !ref_gain_q && !ext_en_q && rst_flag_q;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("reset values wrong");

    property p_mode_forced;
        ext_en_q |-> !mode_q;
    endproperty
    a_mode_forced: assert property (p_mode_forced)
        else $error("mode bit set under external trigger");

    property p_auto_stop;
        (CE_I && auto_eff && ext_en_d) |=> seq_q == SEQ_IDLE;
    endproperty
    a_auto_stop: assert property (p_auto_stop)
        else $error("auto mode kept running after trigger enable");

    c_ext_pass: cover property (ext_en_q && pass_end ##1 done_q);
    c_auto_pulse: cover property (dav_start ##1 !DATA_AVAILABLE_PIN_N_O);
    c_read_clear: cover property (done_q && rd_data ##1 !done_q);
endmodule

/* File: ascr_top_test.sv */
// self-checking bench for the converter status and configuration register
`timescale 1ns/1ps
module ascr_top_test;
    import ascr_pkg::*;
    localparam int CONV = 4;
    localparam int DATA_AVAILABLE_PIN_N = 3;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [15:0] wdata = 16'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic convert;
    logic [11:0] result;
    logic [3:0] adc_ch;
    logic adc_busy;
    logic pin_n;
    logic ref_int;
    logic ref_high;
    logic cs_sel;
    logic cs_gain;
    logic fire = 1'b0;
    logic ce = 1'b1;
    logic [15:0] got;
    logic [3:0] ch_log[$];
    int bad_count = 0;
    int tests_run = 0;

    always #2 clk = ~clk;

    ascr_top #(.CONV_CYCLES(CONV), .DAV_CYCLES(DATA_AVAILABLE_PIN_N)) u_dut (
        .CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .CONVERT_I(convert),
        .ADC_RESULT_I(result), .ADC_CHANNEL_O(adc_ch), .ADC_BUSY_O(adc_busy),
        .DATA_AVAILABLE_PIN_N_O(pin_n), .REF_INT_CONNECT_O(ref_int),
        .REF_LEVEL_HIGH_O(ref_high), .CS_REFERENCE_SELECT_O(cs_sel),
        .CS_REFERENCE_GAIN_O(cs_gain));

    ascr_partner u_partner (.clk_i(clk), .fire_i(fire), .channel_i(adc_ch),
        .convert_o(convert), .result_o(result));

    // channel visiting order, one entry per new channel while busy
    always @(posedge clk) begin
        if (adc_busy === 1'b1 && (ch_log.size() == 0 || adc_ch !== ch_log[$])) begin
            ch_log.push_back(adc_ch);
        end
    end

    task automatic finish_test();
        if (bad_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk1(input logic g, input logic e);
        chk16({15'h0, g}, {15'h0, e});
    endtask

    task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [1:0] a, input logic [15:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk16(rdata, e);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (adc_busy !== 1'b0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        #1 chk1(adc_busy, 1'b0);
    endtask

    task automatic run_direct(input logic [3:0] first, input logic [3:0] last);
        ch_log.delete();
        wr_reg(OFS_CTRL, {4'h0, first, last, 4'h0});
        rd_chk(OFS_STATUS, 16'h0000);
        wait_idle();
        @(posedge clk);
        #1 chk1(pin_n, 1'b0);
    endtask

    task automatic t_reset_and_config();
        rd_chk(OFS_STATUS, 16'h4000);
        chk1(pin_n, 1'b1);
        chk1(ref_int, 1'b1);
        wr_reg(OFS_STATUS, 16'hFFFF);
        rd_chk(OFS_STATUS, 16'h40E0);
        chk1(ref_int, 1'b0);
        chk1(ref_high, 1'b0);
        chk1(cs_sel, 1'b1);
        chk1(cs_gain, 1'b1);
        // supply taken as 5 V, so gain 1 with the internal reference is allowed
        wr_reg(OFS_STATUS, 16'h0040);
        rd_chk(OFS_STATUS, 16'h0040);
        chk1(ref_high, 1'b1);
        chk1(cs_sel, 1'b0);
        wr_reg(OFS_STATUS, 16'h5000);
        rd_chk(OFS_STATUS, 16'h0000);
        rd_chk(2'h3, 16'h0000);
    endtask

    task automatic t_direct();
        run_direct(4'hE, 4'h1);
        chk16(16'(ch_log.size()), 16'h4);
        for (int i = 0; i < 4 && i < ch_log.size(); i++) begin
            chk16({12'h0, ch_log[i]}, {12'h0, 4'hE + 4'(i)});
        end
        rd_chk(OFS_STATUS, 16'h2000);
        wr_reg(OFS_DATA, 16'hFFFF);
        rd_chk(OFS_DATA, 16'h0A01);
        rd_chk(OFS_STATUS, 16'h0000);
        #1 chk1(pin_n, 1'b1);
        run_direct(4'h5, 4'h5);
        wr_reg(OFS_STATUS, 16'h0000);
        rd_chk(OFS_STATUS, 16'h0000);
        run_direct(4'h5, 4'h5);
        wr_reg(OFS_CTRL, 16'h0550);
        rd_chk(OFS_STATUS, 16'h0000);
        wait_idle();
    endtask

    task automatic t_auto();
        int n;
        n = 0;
        wr_reg(OFS_CTRL, 16'h8110);
        // sample off the edge: at the write edge the pin still shows the last direct pass
        #1;
        while (pin_n !== 1'b0 && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        n = 0;
        while (pin_n === 1'b0 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk16(16'(n), 16'(DATA_AVAILABLE_PIN_N));
        rd_chk(OFS_STATUS, 16'h0000);
        chk1(adc_busy, 1'b1);
        wr_reg(OFS_STATUS, 16'h0020);
        repeat (2) @(posedge clk);
        #1 chk1(adc_busy, 1'b0);
        chk1(pin_n, 1'b1);
    endtask

    task automatic t_external();
        ch_log.delete();
        wr_reg(OFS_CTRL, 16'h8330);
        repeat (8) @(posedge clk);
        #1 chk1(adc_busy, 1'b0);
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (4) @(posedge clk);
        wait_idle();
        repeat (8) @(posedge clk);
        #1 chk1(adc_busy, 1'b0);
        chk16(16'(ch_log.size()), 16'h1);
        rd_chk(OFS_STATUS, 16'h2020);
        rd_chk(OFS_DATA, 16'h0A03);
        rd_chk(OFS_CTRL, 16'h0330);
        wr_reg(OFS_STATUS, 16'h0000);
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (8) @(posedge clk);
        #1 chk1(adc_busy, 1'b0);
    endtask

    // frozen write must be lost; reset in mid-run must stop auto mode and restore defaults
    task automatic t_freeze_and_reset();
        ce <= 1'b0;
        wr_reg(OFS_STATUS, 16'h00C0);
        ce <= 1'b1;
        rd_chk(OFS_STATUS, 16'h0000);
        wr_reg(OFS_STATUS, 16'h00C0);
        wr_reg(OFS_CTRL, 16'h8000);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk1(adc_busy, 1'b0);
        chk1(pin_n, 1'b1);
        chk1(ref_int, 1'b1);
        rd_chk(OFS_STATUS, 16'h4000);
        rd_chk(OFS_CTRL, 16'h0000);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_and_config();
        t_direct();
        t_auto();
        t_external();
        t_freeze_and_reset();
        finish_test();
    end

    // whole run is a few hundred cycles; this limit of 50000 cycles is far beyond it
    initial begin
        #200000;
        bad_count++;
        finish_test();
    end
endmodule
